/* logic/sdcs_pkg.sv */
// Package of command codes, field positions and timing constants for the SDRAM command logic.
package sdcs_pkg;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int DQ_W = 16;
  localparam int DQM_W = 2;
  localparam int SCOPE_BIT = 10;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 80;
  localparam int SELF_REFRESH_EXIT_CYC = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_EXIT_NOPS = 2;
  localparam int READ_MASK_DELAY = 2;
  localparam int BURST_LEN = 4;
  // Strobe codes as {row, column, write}.
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACTIVE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_TERM = 3'h6;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  typedef enum logic [4:0] {
    SDCS_BANK_IDLE = 5'h01,
    SDCS_BANK_ACTIVE = 5'h02,
    SDCS_BANK_READ = 5'h04,
    SDCS_BANK_WRITE = 5'h08,
    SDCS_BANK_AUTO_PRE = 5'h10
  } sdcs_bank_e;
  typedef enum logic [3:0] {
    SDCS_CKE_NORMAL = 4'h1,
    SDCS_CKE_POWER_DOWN = 4'h2,
    SDCS_CKE_SELF_REFRESH = 4'h4,
    SDCS_CKE_SUSPEND = 4'h8
  } sdcs_cke_e;
endpackage

/* logic/sdcs_if.sv */
// Interface carrying the SDRAM command, address, mask and data pins between controller and device.
`timescale 1ns/100ps
`default_nettype none
interface sdcs_if;
  import sdcs_pkg::*;
  logic cke;
  logic chip_select_n;
  logic row_strobe_n;
  logic col_strobe_n;
  logic write_enable_n;
  logic [BANK_W-1:0] bank_select;
  logic [ROW_W-1:0] addr;
  logic [DQM_W-1:0] dqm;
  logic [DQ_W-1:0] dq_ctrl_o;
  logic [DQM_W-1:0] dq_ctrl_oe_n;
  logic [DQ_W-1:0] dq_dev_o;
  logic [DQM_W-1:0] dq_dev_oe_n;
  logic [DQ_W-1:0] dq;
  // Each byte lane takes whichever end enables it, controller first.
  always_comb begin
    for (int i = 0; i < DQ_W; i++) begin
      dq[i] = !dq_ctrl_oe_n[i/8] ? dq_ctrl_o[i] : (!dq_dev_oe_n[i/8] ? dq_dev_o[i] : 1'b0);
    end
  end
  modport ctrl (output cke, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n, bank_select, addr, dqm,
    dq_ctrl_o, dq_ctrl_oe_n, input dq);
  modport dev (input cke, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n, bank_select, addr, dqm, dq,
    output dq_dev_o, dq_dev_oe_n);
endinterface
`default_nettype wire

/* logic/sdcs_bank.sv */
// One bank's state tracker, instantiated per bank by the device end.
`timescale 1ns/100ps
`default_nettype none
module sdcs_bank
  import sdcs_pkg::*;
#(
  parameter int BURST = BURST_LEN
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_act,
  input wire logic cmd_rd,
  input wire logic cmd_wr,
  input wire logic cmd_pre,
  input wire logic cmd_stop,
  input wire logic auto_pre,
  // High while the clock is disabled; a burst then stands still.
  input wire logic hold,
  input wire logic [ROW_W-1:0] row,
  output sdcs_bank_e state,
  output logic [ROW_W-1:0] open_row
);
  initial if (BURST < 1) $error("Burst length must be at least one.");
  sdcs_bank_e state_reg, state_next;
  logic [ROW_W-1:0] row_reg;
  logic [7:0] beat_reg;
  wire burst_done = (beat_reg == 8'(BURST - 1));
  wire in_burst = (state_reg == SDCS_BANK_READ) || (state_reg == SDCS_BANK_WRITE) ||
    (state_reg == SDCS_BANK_AUTO_PRE);
  // Next state per bank; each bank checks commands against its own state only.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SDCS_BANK_IDLE: if (cmd_act) state_next = SDCS_BANK_ACTIVE;
      SDCS_BANK_ACTIVE: begin
        if (cmd_pre) state_next = SDCS_BANK_IDLE;
        else if (cmd_rd || cmd_wr) state_next = auto_pre ? SDCS_BANK_AUTO_PRE : (cmd_rd ? SDCS_BANK_READ : SDCS_BANK_WRITE);
      end
      SDCS_BANK_READ, SDCS_BANK_WRITE: begin
        if (cmd_pre) state_next = SDCS_BANK_IDLE;
        else if (cmd_rd || cmd_wr) state_next = auto_pre ? SDCS_BANK_AUTO_PRE : (cmd_rd ? SDCS_BANK_READ : SDCS_BANK_WRITE);
        else if (cmd_stop || burst_done) state_next = SDCS_BANK_ACTIVE;
      end
      SDCS_BANK_AUTO_PRE: if (burst_done || cmd_stop) state_next = SDCS_BANK_IDLE;
      default: state_next = SDCS_BANK_IDLE;
    endcase
  end
  // A new burst restarts the beat count; it freezes outside bursts and while the clock is suspended.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SDCS_BANK_IDLE;
      row_reg <= '0;
      beat_reg <= '0;
    end else if (!hold) begin
      state_reg <= state_next;
      if (cmd_act && state_reg == SDCS_BANK_IDLE) row_reg <= row;
      if (cmd_rd || cmd_wr) beat_reg <= '0;
      else if (in_burst && !burst_done) beat_reg <= beat_reg + 8'h01;
    end
  end
  assign state = state_reg;
  assign open_row = row_reg;
endmodule
`default_nettype wire

/* logic/sdcs_device.sv */
// Device end: command decode, clock-enable modes, per-bank state, mode register and data masks.
//
// Overview of operation
// - chip select low decodes active, read, write.
// - inhibit ignored; no-op continues current work.
// - terminate, precharge, load mode, refresh encodings.
// - controller drops enable only for no-op or refresh requests.
// - load mode captures address bits 0-11.
// - active opens addressed row in selected bank.
// - column bits 0-7; bit 10 auto precharge.
// - scope bit picks one or all banks.
// - refresh with enable low enters self refresh.
// - refresh uses internal row counter.
// - mask blocks writes now, reads two later.
// - write data valid with write command.
// - enable history selects power-down, suspend modes.
// - power-down exit idles by next edge.
// - controller sends no-ops during self-refresh exit.
// - suspend exit resumes; next edge accepts commands.
// - controller issues only listed combinations.
// - idle and active banks accept listed commands.
// - read burst accepts read, write, terminate, precharge.
// - write burst accepts read, write, terminate, precharge.
// - self refresh held while enable low.
// - terminate cuts most recent burst, any bank.
// - precharge to idle bank acts as no-op.
`timescale 1ns/100ps
`default_nettype none
module sdcs_device
  import sdcs_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Pins from the controller.
  sdcs_if.dev PINS,
  // Internal state shown to the user side.
  output logic [ROW_W-1:0] MODE_REG,
  output logic [4*NUM_BANKS-1:0] BANK_STATE,
  output logic [3:0] CKE_MODE,
  output logic [ROW_W-1:0] REFRESH_ROW,
  output logic [COL_W-1:0] LAST_COL,
  output logic WRITE_STROBE,
  output logic [DQ_W-1:0] WRITE_DATA,
  output logic [DQM_W-1:0] WRITE_BYTE_EN,
  // Read data the array returns.
  input wire logic [DQ_W-1:0] READ_DATA
);
  import sdcs_pkg::*;
  sdcs_cke_e cke_mode_reg, cke_mode_next;
  logic cke_prev_reg;
  logic [ROW_W-1:0] mode_reg, refresh_row_reg;
  logic [COL_W-1:0] col_reg;
  logic last_burst_read_reg;
  logic [BANK_W-1:0] last_bank_reg;
  logic [DQM_W-1:0] dqm_pipe_reg [READ_MASK_DELAY];
  logic [DQ_W-1:0] wdata_reg, rdata_reg;
  logic [DQM_W-1:0] wben_reg;
  logic wstrobe_reg;
  logic [DQM_W-1:0] rd_oe_n_reg;
  sdcs_bank_e bank_state [NUM_BANKS];
  // Commands only count at edges where the clock is enabled and no low-power mode is held.
  wire [2:0] strobes = {PINS.row_strobe_n, PINS.col_strobe_n, PINS.write_enable_n};
  wire sel = !PINS.chip_select_n;
  wire live = (cke_mode_reg == SDCS_CKE_NORMAL) && cke_prev_reg;
  wire go = sel && live && PINS.cke;
  wire is_act = go && strobes == CMD_ACTIVE;
  wire is_rd = go && strobes == CMD_READ;
  wire is_wr = go && strobes == CMD_WRITE;
  wire is_stop = go && strobes == CMD_TERM;
  wire is_pre = go && strobes == CMD_PRECHARGE;
  wire is_lmr = go && strobes == CMD_LOAD_MODE;
  wire is_ref_raw = sel && live && strobes == CMD_REFRESH;
  wire is_auto_ref = is_ref_raw && PINS.cke;
  wire is_self_ref = is_ref_raw && !PINS.cke;
  wire nop_or_inh = !sel || strobes == CMD_NOP;
  wire scope = PINS.addr[SCOPE_BIT];
  // Burst activity and idle status over all banks.
  logic [NUM_BANKS-1:0] bank_idle, bank_burst;
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      wire hit = PINS.bank_select == BANK_W'(b);
      wire stop_here = is_stop && last_bank_reg == BANK_W'(b);
      sdcs_bank #(.BURST(BURST_LEN)) u_bank (
        .clk(SYS_CLK),
        .srst(SRST),
        .cmd_act(is_act && hit),
        .cmd_rd(is_rd && hit),
        .cmd_wr(is_wr && hit),
        .cmd_pre(is_pre && (scope || hit)),
        .cmd_stop(stop_here),
        .auto_pre(scope),
        .hold(!PINS.cke),
        .row(PINS.addr),
        .state(bank_state[b]),
        .open_row()
      );
      assign bank_idle[b] = bank_state[b] == SDCS_BANK_IDLE;
      assign bank_burst[b] = bank_state[b] == SDCS_BANK_READ || bank_state[b] == SDCS_BANK_WRITE ||
        bank_state[b] == SDCS_BANK_AUTO_PRE;
      assign BANK_STATE[4*b +: 4] = {bank_state[b] == SDCS_BANK_AUTO_PRE, bank_state[b] == SDCS_BANK_WRITE,
        bank_state[b] == SDCS_BANK_READ, bank_state[b] == SDCS_BANK_ACTIVE};
    end
  endgenerate
  wire all_idle = &bank_idle;
  wire any_burst = |bank_burst;
  // Clock-enable mode from previous and current enable samples.
  always_comb begin
    cke_mode_next = cke_mode_reg;
    unique case (cke_mode_reg)
      SDCS_CKE_NORMAL: begin
        if (cke_prev_reg && !PINS.cke) begin
          if (is_self_ref && all_idle) cke_mode_next = SDCS_CKE_SELF_REFRESH;
          else if (any_burst) cke_mode_next = SDCS_CKE_SUSPEND;
          else if (all_idle && nop_or_inh) cke_mode_next = SDCS_CKE_POWER_DOWN;
        end
      end
      SDCS_CKE_POWER_DOWN: if (PINS.cke && nop_or_inh) cke_mode_next = SDCS_CKE_NORMAL;
      SDCS_CKE_SELF_REFRESH: if (PINS.cke && nop_or_inh) cke_mode_next = SDCS_CKE_NORMAL;
      SDCS_CKE_SUSPEND: if (PINS.cke) cke_mode_next = SDCS_CKE_NORMAL;
      default: cke_mode_next = SDCS_CKE_NORMAL;
    endcase
  end
  // Mode, refresh counter and last-burst bookkeeping.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cke_mode_reg <= SDCS_CKE_NORMAL;
      cke_prev_reg <= 1'b1;
      mode_reg <= '0;
      refresh_row_reg <= '0;
      col_reg <= '0;
      last_bank_reg <= '0;
      last_burst_read_reg <= 1'b0;
    end else begin
      cke_mode_reg <= cke_mode_next;
      cke_prev_reg <= PINS.cke;
      if (is_lmr && all_idle) mode_reg <= PINS.addr;
      if ((is_auto_ref && all_idle) || cke_mode_reg == SDCS_CKE_SELF_REFRESH) begin
        refresh_row_reg <= refresh_row_reg + 12'h001;
      end
      if (is_rd || is_wr) begin
        col_reg <= PINS.addr[COL_W-1:0];
        last_bank_reg <= PINS.bank_select;
        last_burst_read_reg <= is_rd;
      end
    end
  end
  // Write data and masks are sampled with the command; read masks act two edges later.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wstrobe_reg <= 1'b0;
      wdata_reg <= '0;
      wben_reg <= '0;
      rdata_reg <= '0;
      rd_oe_n_reg <= '1;
      for (int i = 0; i < READ_MASK_DELAY; i++) dqm_pipe_reg[i] <= '1;
    end else begin
      wstrobe_reg <= is_wr || (live && PINS.cke && bank_state[last_bank_reg] == SDCS_BANK_WRITE);
      wdata_reg <= PINS.dq;
      wben_reg <= ~PINS.dqm;
      dqm_pipe_reg[0] <= PINS.dqm;
      for (int i = 1; i < READ_MASK_DELAY; i++) dqm_pipe_reg[i] <= dqm_pipe_reg[i-1];
      rdata_reg <= READ_DATA;
      rd_oe_n_reg <= (last_burst_read_reg && any_burst) ? dqm_pipe_reg[READ_MASK_DELAY-1] : '1;
    end
  end
  assign PINS.dq_dev_o = rdata_reg;
  assign PINS.dq_dev_oe_n = rd_oe_n_reg;
  assign MODE_REG = mode_reg;
  assign CKE_MODE = cke_mode_reg;
  assign REFRESH_ROW = refresh_row_reg;
  assign LAST_COL = col_reg;
  assign WRITE_STROBE = wstrobe_reg;
  assign WRITE_DATA = wdata_reg;
  assign WRITE_BYTE_EN = wben_reg;
endmodule
`default_nettype wire

/* logic/sdcs_ctrl.sv */
// Controller end: turns user requests into legal command pin patterns.
`timescale 1ns/100ps
`default_nettype none
module sdcs_ctrl
  import sdcs_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Request from the user side.
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [2:0] REQ_CMD,
  input wire logic [BANK_W-1:0] REQ_BANK,
  input wire logic [ROW_W-1:0] REQ_ADDR,
  input wire logic [DQ_W-1:0] REQ_WDATA,
  input wire logic [DQM_W-1:0] REQ_MASK,
  input wire logic REQ_CKE_LOW,
  // Read data seen on the pins.
  output logic [DQ_W-1:0] RD_DATA,
  // Pins to the device.
  sdcs_if.ctrl PINS
);
  import sdcs_pkg::*;
  logic cke_reg, cs_n_reg, wr_drive_reg;
  logic [2:0] strobes_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [ROW_W-1:0] addr_reg;
  logic [DQ_W-1:0] wdata_reg, rdata_reg;
  logic [DQM_W-1:0] dqm_reg;
  logic [7:0] exit_cnt_reg;
  // Exit from low enable needs a run of no-ops before any real command.
  wire exiting = exit_cnt_reg != 8'h00;
  wire low_ok = REQ_CMD == CMD_REFRESH || REQ_CMD == CMD_NOP;
  assign REQ_READY = !exiting;
  wire take = REQ_VALID && REQ_READY;
  wire want_low = take && REQ_CKE_LOW && low_ok;
  localparam int EXIT_CYC = (SELF_REFRESH_EXIT_CYC > MIN_EXIT_NOPS) ? SELF_REFRESH_EXIT_CYC : MIN_EXIT_NOPS;
  // Registered pins; idle cycles deselect the chip with enable kept as last requested.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cke_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      strobes_reg <= CMD_NOP;
      bank_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      dqm_reg <= '0;
      wr_drive_reg <= 1'b0;
      exit_cnt_reg <= '0;
      rdata_reg <= '0;
    end else begin
      rdata_reg <= PINS.dq;
      if (exiting) begin
        exit_cnt_reg <= exit_cnt_reg - 8'h01;
        cs_n_reg <= 1'b0;
        strobes_reg <= CMD_NOP;
        wr_drive_reg <= 1'b0;
      end else if (take) begin
        cke_reg <= !want_low;
        if (!cke_reg && !want_low) exit_cnt_reg <= 8'(EXIT_CYC);
        cs_n_reg <= 1'b0;
        strobes_reg <= REQ_CMD;
        bank_reg <= REQ_BANK;
        addr_reg <= REQ_ADDR;
        wdata_reg <= REQ_WDATA;
        dqm_reg <= REQ_MASK;
        wr_drive_reg <= REQ_CMD == CMD_WRITE;
      end else begin
        cs_n_reg <= 1'b1;
        strobes_reg <= CMD_NOP;
        wr_drive_reg <= 1'b0;
      end
    end
  end
  assign PINS.cke = cke_reg;
  assign PINS.chip_select_n = cs_n_reg;
  assign {PINS.row_strobe_n, PINS.col_strobe_n, PINS.write_enable_n} = strobes_reg;
  assign PINS.bank_select = bank_reg;
  assign PINS.addr = addr_reg;
  assign PINS.dqm = dqm_reg;
  assign PINS.dq_ctrl_o = wdata_reg;
  assign PINS.dq_ctrl_oe_n = {DQM_W{!wr_drive_reg}};
  assign RD_DATA = rdata_reg;
endmodule
`default_nettype wire

/* dv/sdcs_sva.sv */
// Checker of controller and device behaviour seen on the shared SDRAM pins.
`timescale 1ns/100ps
`default_nettype none
module sdcs_sva
  import sdcs_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Pins between the two ends.
  input wire logic cke,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic [DQM_W-1:0] dqm,
  input wire logic [DQM_W-1:0] dq_ctrl_oe_n,
  input wire logic [DQM_W-1:0] dq_dev_oe_n
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // Decoded view of the command pins.
  wire [2:0] cmd = {row_strobe_n, col_strobe_n, write_enable_n};
  wire quiet = chip_select_n || (cmd == CMD_NOP);
  wire is_wr = !chip_select_n && (cmd == CMD_WRITE);
  wire is_rd = !chip_select_n && (cmd == CMD_READ);
  wire is_ref = !chip_select_n && (cmd == CMD_REFRESH);
  logic [3:0] rd_age_reg;
  // Age of the last read; it freezes in suspend, where a burst stands still.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rd_age_reg <= 4'hF;
    end else if (is_rd) begin
      rd_age_reg <= 4'h0;
    end else if (cke && rd_age_reg != 4'hF) begin
      rd_age_reg <= rd_age_reg + 4'h1;
    end
  end
  sequence nop_s;
    !chip_select_n && cmd == CMD_NOP;
  endsequence
  sequence exit_s;
    quiet ##1 nop_s ##1 nop_s;
  endsequence
  AST_CKE_FALL: assert property ($fell(cke) |-> quiet || is_ref)
    else $error("Clock enable fell with a command other than no-op or refresh.");
  AST_CKE_LOW_QUIET: assert property (!cke && !$past(cke) |-> quiet)
    else $error("A command was issued while clock enable stayed low.");
  AST_EXIT_NOPS: assert property ($rose(cke) |-> exit_s)
    else $error("Clock enable rose without the following no-op commands.");
  AST_CMD_CKE: assert property (!quiet && !is_ref |-> cke)
    else $error("A command was issued with clock enable low.");
  AST_WR_DATA: assert property (is_wr |-> ((~dq_ctrl_oe_n | dqm) == 2'h3))
    else $error("Write command without data on an unmasked lane.");
  AST_NO_CLASH: assert property ((~dq_ctrl_oe_n & ~dq_dev_oe_n) == 2'h0)
    else $error("Both ends drive one data lane.");
  // The enable seen here was launched one edge ago, so its mask was taken two edges before that.
  AST_RD_MASK: assert property ((~dq_dev_oe_n & $past(dqm, 3)) == 2'h0)
    else $error("Device drove a lane masked two clocks earlier.");
  AST_STRAY_DRIVE: assert property (dq_dev_oe_n != 2'h3 |-> rd_age_reg < 4'hB)
    else $error("Device drove data with no read in progress.");
endmodule
`default_nettype wire

/* dv/sdcs_tb_top.sv */
// Self-checking bench joining the controller and device ends over the shared pins.
`timescale 1ns/100ps
`default_nettype none
module sdcs_tb_top;
  import sdcs_pkg::*;
  typedef struct packed {
    logic [2:0] cmd;
    logic [1:0] bank;
    logic [11:0] addr;
    logic [15:0] wd;
    logic [1:0] mask;
    logic [1:0] sel;
    logic [15:0] want;
    logic [15:0] want_bs;
  } sdcs_row_s;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic [2:0] req_cmd = CMD_NOP;
  logic [BANK_W-1:0] req_bank = 2'h0;
  logic [ROW_W-1:0] req_addr = 12'h000;
  logic [DQ_W-1:0] req_wdata = 16'h0000;
  logic [DQM_W-1:0] req_mask = 2'h0;
  logic req_cke_low = 1'b0;
  logic [DQ_W-1:0] read_data = 16'hA55A;
  logic req_ready;
  logic write_strobe;
  logic [ROW_W-1:0] mode_reg;
  logic [15:0] bank_state;
  logic [3:0] cke_mode;
  logic [ROW_W-1:0] refresh_row;
  logic [ROW_W-1:0] row_was;
  logic [COL_W-1:0] last_col;
  logic [DQ_W-1:0] write_data;
  logic [DQ_W-1:0] rd_data;
  logic [DQM_W-1:0] write_byte_en;
  logic [15:0] got;
  logic seen;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // Ordinary commands with the state each should leave behind.
  sdcs_row_s rows [15] = '{
    '{CMD_LOAD_MODE, 2'h0, 12'h5A3, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0000},
    '{CMD_ACTIVE, 2'h1, 12'h123, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0010},
    '{CMD_WRITE, 2'h1, 12'h0C7, 16'hBEEF, 2'h2, 2'h2, 16'h0001, 16'h0040},
    '{CMD_TERM, 2'h0, 12'h000, 16'h0000, 2'h0, 2'h1, 16'h00C7, 16'h0010},
    '{CMD_READ, 2'h1, 12'h03C, 16'h0000, 2'h0, 2'h1, 16'h003C, 16'h0020},
    '{CMD_PRECHARGE, 2'h1, 12'h000, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0000},
    '{CMD_ACTIVE, 2'h0, 12'h010, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0001},
    '{CMD_ACTIVE, 2'h3, 12'h020, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h1001},
    '{CMD_WRITE, 2'h3, 12'h011, 16'h1234, 2'h0, 2'h2, 16'h0003, 16'h4001},
    '{CMD_PRECHARGE, 2'h3, 12'h000, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0001},
    '{CMD_PRECHARGE, 2'h2, 12'h000, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0001},
    '{CMD_PRECHARGE, 2'h2, 12'h400, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0000},
    '{CMD_REFRESH, 2'h0, 12'h000, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0000},
    '{CMD_ACTIVE, 2'h2, 12'h0AB, 16'h0000, 2'h0, 2'h0, 16'h05A3, 16'h0100},
    '{CMD_WRITE, 2'h2, 12'h405, 16'h5678, 2'h0, 2'h1, 16'h0005, 16'h0800}};
  sdcs_if sdcs_if_i();
  sdcs_ctrl sdcs_ctrl_i (.SYS_CLK(sys_clk), .SRST(srst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_CMD(req_cmd), .REQ_BANK(req_bank), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_MASK(req_mask),
    .REQ_CKE_LOW(req_cke_low), .RD_DATA(rd_data), .PINS(sdcs_if_i));
  sdcs_device sdcs_device_i (.SYS_CLK(sys_clk), .SRST(srst), .PINS(sdcs_if_i), .MODE_REG(mode_reg),
    .BANK_STATE(bank_state), .CKE_MODE(cke_mode), .REFRESH_ROW(refresh_row), .LAST_COL(last_col),
    .WRITE_STROBE(write_strobe), .WRITE_DATA(write_data), .WRITE_BYTE_EN(write_byte_en), .READ_DATA(read_data));
  sdcs_sva sdcs_sva_i (.SYS_CLK(sys_clk), .SRST(srst), .cke(sdcs_if_i.cke), .chip_select_n(sdcs_if_i.chip_select_n),
    .row_strobe_n(sdcs_if_i.row_strobe_n), .col_strobe_n(sdcs_if_i.col_strobe_n),
    .write_enable_n(sdcs_if_i.write_enable_n), .dqm(sdcs_if_i.dqm), .dq_ctrl_oe_n(sdcs_if_i.dq_ctrl_oe_n),
    .dq_dev_oe_n(sdcs_if_i.dq_dev_oe_n));
  always #10 sys_clk = ~sys_clk;
  // A hung handshake ends the run here rather than stalling forever.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] w);
    num_checks++;
    if (g !== w) begin
      errors++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, g, w);
    end
  endtask
  // Entered one step after an edge; holds the request until an edge with ready high.
  task automatic req(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d,
      input logic [1:0] m, input logic lo);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_wdata = d;
    req_mask = m;
    req_cke_low = lo;
    while (req_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
  endtask
  task automatic idle(input int n);
    req_valid = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  initial begin
    idle(6);
    srst = 1'b0;
    chk({12'h0, cke_mode}, 16'h0001);
    for (int i = 0; i < 15; i++) begin
      req(rows[i].cmd, rows[i].bank, rows[i].addr, rows[i].wd, rows[i].mask, 1'b0);
      idle(1);
      chk(bank_state, rows[i].want_bs);
      case (rows[i].sel)
        2'h0: got = {4'h0, mode_reg};
        2'h1: got = {8'h0, last_col};
        default: got = {14'h0, write_byte_en};
      endcase
      chk(got, rows[i].want);
    end
    // The auto precharge write must close its bank once the burst ends.
    idle(8);
    chk(bank_state, 16'h0000);
    req(CMD_NOP, 2'h0, 12'h000, 16'h0000, 2'h0, 1'b1);
    idle(3);
    chk({12'h0, cke_mode}, 16'h0002);
    req(CMD_NOP, 2'h0, 12'h000, 16'h0000, 2'h0, 1'b0);
    idle(1);
    chk({12'h0, cke_mode}, 16'h0001);
    req(CMD_REFRESH, 2'h0, 12'h000, 16'h0000, 2'h0, 1'b1);
    idle(1);
    row_was = refresh_row;
    idle(4);
    chk({12'h0, cke_mode}, 16'h0004);
    chk({15'h0, refresh_row !== row_was}, 16'h0001);
    req(CMD_NOP, 2'h0, 12'h000, 16'h0000, 2'h0, 1'b0);
    idle(6);
    chk({12'h0, cke_mode}, 16'h0001);
    // Suspend lands one beat into a read, so the burst must still stand afterwards.
    req(CMD_ACTIVE, 2'h0, 12'h001, 16'h0000, 2'h0, 1'b0);
    idle(1);
    req(CMD_READ, 2'h0, 12'h000, 16'h0000, 2'h0, 1'b0);
    req(CMD_NOP, 2'h0, 12'h000, 16'h0000, 2'h0, 1'b1);
    idle(4);
    chk({12'h0, cke_mode}, 16'h0008);
    chk(bank_state, 16'h0002);
    req(CMD_NOP, 2'h0, 12'h000, 16'h0000, 2'h0, 1'b0);
    idle(1);
    chk({12'h0, cke_mode}, 16'h0001);
    idle(10);
    chk(bank_state, 16'h0001);
    req(CMD_READ, 2'h0, 12'h008, 16'h0000, 2'h1, 1'b0);
    seen = 1'b0;
    idle(0);
    repeat (8) begin
      idle(1);
      if (rd_data[15:8] === 8'hA5) begin
        seen = 1'b1;
      end
    end
    chk({15'h0, seen}, 16'h0001);
    // A second reset in mid-run must clear every bank.
    req(CMD_ACTIVE, 2'h2, 12'h002, 16'h0000, 2'h0, 1'b0);
    idle(1);
    srst = 1'b1;
    idle(2);
    chk(bank_state, 16'h0000);
    chk({12'h0, cke_mode}, 16'h0001);
    srst = 1'b0;
    idle(2);
    close_out();
  end
endmodule
`default_nettype wire
